//--- logic/xp_gen_pkg.sv
/*
 * Constants for the crosspoint pulse generator: time pulse numbering,
 * widths of the counter cell group and of the write bus.
 * Assumes a one-hot twelve-step time pulse sequence from the timer.
 */
package xp_gen_pkg;
   localparam int TP_COUNT         = 12;  // Time pulses per memory cycle
   localparam int TP_ONE           = 0;   // Index of first time pulse
   localparam int TP_TWO           = 1;
   localparam int TP_THREE         = 2;
   localparam int TP_FOUR          = 3;
   localparam int TP_SEVEN         = 6;
   localparam int TP_TEN           = 9;
   localparam int TP_TWELVE        = 11;
   localparam int BUS_WIDTH        = 16;  // Write bus width
   localparam int LOW_BITS         = 10;  // Bits moved by the low-ten xp
   localparam int CELL_COUNT       = 20;  // Counter cells
   localparam logic [11:0] TP_RESET = 12'h000;
endpackage : xp_gen_pkg

//--- logic/crosspoint_pulse_generator.sv
/*
 * Crosspoint pulse generator: ANDs command signals with one-hot time
 * pulses, sets counter-instruction flops and drives the control pulses
 * that move data between registers and memory. Also holds the write
 * bus copy, the memory address register and the memory buffer that
 * these pulses load, so that their effect can be seen at the ports.
 * Assumes all command inputs come from logic on clk_in, and that the
 * timer supplies one-hot time pulses in step with the memory cycle.
 * Assumes commands stay steady from one pulse twelve to the next, and
 * that clk_en_in is low only to freeze the whole block at once.
 */
// How it works
// - Counter flops set on time pulse two when the set gate is on.
// - Set gate needs next-sequence flop set and no peripheral busy.
// - A set counter flop stays set from pulse two through twelve.
// - At most one counter cell signal is active at a time.
// - Pulse-one counter pulses come from the counter command.
// - Each crosspoint is a command ANDed with its time pulse.
// - Conditional skip uses branch qualification on pulses seven, ten.
// - Low-ten crosspoint on pulse one for its listed command group.
// - Low-ten xp puts ten buffer bits on the bus and makes address write.
// - Address write pulse loads the write bus into the address register.
// - Fetch crosspoint on pulse two gives read, write unless suppressed.
// - Erasable address: write clears the buffer, central read held back.
// - Central register address: timing off, register copied to buffer.
// - Skip never reaches fixed memory: bits twelve and eleven stay off.
// - Conditional skip emits nothing on time pulses three and four.
// - Conditional skip loads erasable word into buffer on pulse four.
// - Some crosspoints are control pulses; others pass control gating.
`timescale 1ns/1ps
`default_nettype none
module crosspoint_pulse_generator #(
   parameter int BUS_W   = xp_gen_pkg::BUS_WIDTH,
   parameter int CELLS   = xp_gen_pkg::CELL_COUNT
) (
   // Clock, reset and enable
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire logic               clk_en_in,
   // Timer
   input  wire logic               cycle_start_in,
   // Counter instruction control
   input  wire logic               next_seq_load_flop_in,
   input  wire logic               peripheral_busy_in,
   input  wire logic [CELLS-1:0]   cell_request_in,
   input  wire logic               counter_instr_cmd_in,
   // Commands
   input  wire logic               cond_skip_sub0_in,
   input  wire logic               skip_instr_cmd_in,
   input  wire logic               double_add_sub0_in,
   input  wire logic               double_add_sub1_in,
   input  wire logic               index_nine_cmd_in,
   input  wire logic               double_exchange_sub0_in,
   input  wire logic               interrupt_count_cmd_in,
   input  wire logic               io_cmd_in,
   input  wire logic               multiply_step_one_in,
   input  wire logic               multiply_step_three_in,
   input  wire logic               divide_step_zero_in,
   input  wire logic               index_fifteen_cmd_in,
   input  wire logic               divide_step_group_in,
   // Branch commands
   input  wire logic               branch_one_in,
   input  wire logic               branch_two_in,
   // Data path
   input  wire logic [BUS_W-1:0]   buffer_reg_in,
   input  wire logic [BUS_W-1:0]   central_reg_in,
   input  wire logic [BUS_W-1:0]   erasable_word_in,
   input  wire logic               central_addr_in,
   input  wire logic               erasable_addr_in,
   // Time pulse and crosspoint outputs
   output logic [11:0]             time_pulse_out,
   output logic [CELLS-1:0]        counter_flops_out,
   output logic                    counter_set_gate_out,
   output logic                    counter_t1_pulse_out,
   output logic                    low_ten_bits_xp_out,
   output logic                    addr_reg_write_pulse_out,
   output logic                    involuntary_fetch_xp_out,
   output logic                    central_reg_read_pulse_out,
   output logic                    membuf_write_pulse_out,
   output logic                    membuf_clear_out,
   output logic                    mem_timing_off_out,
   output logic [2:0]              skip_branch_xp_out,
   // Registers
   output logic [BUS_W-1:0]        write_bus_out,
   output logic [BUS_W-1:0]        addr_reg_out,
   output logic [BUS_W-1:0]        membuf_out
);

   // Elaboration checks: the bus must reach bits twelve and eleven
   if (BUS_W < 12) begin : g_bad_bus
      $error("crosspoint_pulse_generator: BUS_W below 12");
   end

   // At least one counter cell is needed for the set logic to mean anything
   if (CELLS < 1) begin : g_bad_cells
      $error("crosspoint_pulse_generator: CELLS below 1");
   end

   // The ring below is twelve bits wide and cannot follow another count
   if (xp_gen_pkg::TP_COUNT != 12) begin : g_bad_ring
      $error("crosspoint_pulse_generator: ring must have twelve pulses");
   end

   // Timing: the ring advances one pulse per enabled edge. Every output
   // but counter_set_gate_out is registered from the ring state, so a pulse shows one edge after
   // the ring reaches it, in the same cycle as its copy on time_pulse_out.
   // Commands must be settled by the edge that sees their pulse.
   // Limitation: the ring free-runs once started; there is no stop.

   // Time pulse ring state and run flag
   logic [11:0]      tp_q;
   logic             running_q;

   // Counter instruction terms
   logic [CELLS-1:0] cell_onehot;
   logic             cells_seen;
   logic             set_gate;
   logic             counter_t1_d;
   logic             counter_set_now;
   logic             counter_clear_now;

   // Crosspoint terms
   logic             low_ten_cmd;
   logic             fetch_inhibit;
   logic             low_ten_d;
   logic             fetch_d;
   logic             skip_quiet;
   logic [2:0]       skip_branch_d;

   // Data path terms
   logic [BUS_W-1:0] bus_d;
   logic             skip_load;
   logic             central_copy;
   logic             erasable_clear;

   // Lowest requesting cell wins, so only one cell is ever selected
   function automatic logic [CELLS-1:0] pick_one(
      input logic [CELLS-1:0] r
   );
      logic [CELLS-1:0] o;
      o = '0;
      for (int i = CELLS - 1; i >= 0; i--) begin
         if (r[i]) begin
            o    = '0;
            o[i] = 1'b1;
         end
      end
      return o;
   endfunction : pick_one

   // Test one time pulse of the ring; used by every crosspoint term
   function automatic logic at_tp(
      input logic [11:0] tp,
      input int          idx
   );
      return tp[idx];
   endfunction : at_tp

   // Time pulse ring; a start is only taken while the ring is idle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tp_q      <= xp_gen_pkg::TP_RESET;
         running_q <= 1'b0;
      end else if (clk_en_in) begin
         if (cycle_start_in && !running_q) begin
            tp_q      <= 12'h001;
            running_q <= 1'b1;
         end else if (running_q) begin
            tp_q <= {tp_q[10:0], tp_q[11]};
         end
      end
   end

   // Counter set gate and cell choice
   always_comb begin
      set_gate    = next_seq_load_flop_in &&
                    !peripheral_busy_in;
      cell_onehot = pick_one(cell_request_in);
      cells_seen  = |cell_onehot;
      // A flop is only written when a cell is actually asking
      counter_set_now   = at_tp(tp_q, xp_gen_pkg::TP_TWO) &&
                          set_gate && cells_seen;
      // Clearing on pulse one keeps the flops up through pulse twelve;
      // clearing on twelve itself would drop them one pulse too early
      counter_clear_now = at_tp(tp_q, xp_gen_pkg::TP_ONE);
      counter_t1_d      = at_tp(tp_q, xp_gen_pkg::TP_ONE) &&
                          counter_instr_cmd_in;
   end

   // Command groups for the first and second time pulses
   always_comb begin
      low_ten_cmd   = skip_instr_cmd_in || double_add_sub0_in ||
                      double_add_sub1_in || index_nine_cmd_in ||
                      double_exchange_sub0_in ||
                      interrupt_count_cmd_in || io_cmd_in;
      // These commands borrow pulse two for their own transfers
      fetch_inhibit = multiply_step_one_in || multiply_step_three_in ||
                      divide_step_zero_in || io_cmd_in ||
                      index_fifteen_cmd_in ||
                      divide_step_group_in;
   end

   // Crosspoints: a command ANDed with its time pulse
   always_comb begin
      low_ten_d  = at_tp(tp_q, xp_gen_pkg::TP_ONE) &&
                   low_ten_cmd;
      fetch_d    = at_tp(tp_q, xp_gen_pkg::TP_TWO) &&
                   !fetch_inhibit;
      // Skip is silent on three and four; kept as a guard, not a mux
      skip_quiet = cond_skip_sub0_in &&
                   (at_tp(tp_q, xp_gen_pkg::TP_THREE) ||
                    at_tp(tp_q, xp_gen_pkg::TP_FOUR));
   end

   // Branch-qualified skip crosspoints on pulses seven and ten
   always_comb begin
      skip_branch_d[0] = cond_skip_sub0_in &&
                         at_tp(tp_q, xp_gen_pkg::TP_SEVEN) &&
                         branch_two_in;
      skip_branch_d[1] = cond_skip_sub0_in &&
                         at_tp(tp_q, xp_gen_pkg::TP_SEVEN) &&
                         branch_one_in;
      skip_branch_d[2] = cond_skip_sub0_in &&
                         at_tp(tp_q, xp_gen_pkg::TP_TEN) &&
                         !branch_two_in;
   end

   // Data path selects
   always_comb begin
      // Only the low ten bits reach the bus; twelve and eleven stay zero
      bus_d = '0;
      if (low_ten_d) begin
         bus_d[xp_gen_pkg::LOW_BITS-1:0] =
            buffer_reg_in[xp_gen_pkg::LOW_BITS-1:0];
      end
      // A skip load on four never meets a fetch on two, so order is free
      skip_load      = cond_skip_sub0_in &&
                       at_tp(tp_q, xp_gen_pkg::TP_FOUR);
      central_copy   = fetch_d && central_addr_in;
      erasable_clear = fetch_d && erasable_addr_in;
   end

   // Counter-instruction flops and their companion pulses
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         counter_flops_out    <= '0;
         counter_set_gate_out <= 1'b0;
         counter_t1_pulse_out <= 1'b0;
      end else if (clk_en_in) begin
         counter_set_gate_out <= set_gate;
         counter_t1_pulse_out <= counter_t1_d;
         if (counter_set_now) begin
            counter_flops_out <= cell_onehot;
         end else if (counter_clear_now) begin
            counter_flops_out <= '0;
         end
      end
   end

   // Time pulse copy and first-pulse crosspoints
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         time_pulse_out           <= xp_gen_pkg::TP_RESET;
         low_ten_bits_xp_out      <= 1'b0;
         addr_reg_write_pulse_out <= 1'b0;
      end else if (clk_en_in) begin
         time_pulse_out           <= tp_q;
         // Used straight as a control pulse: no gating behind it
         low_ten_bits_xp_out      <= low_ten_d && !skip_quiet;
         addr_reg_write_pulse_out <= low_ten_d && !skip_quiet;
      end
   end

   // Involuntary fetch and the read and write pulses made from it
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         involuntary_fetch_xp_out   <= 1'b0;
         central_reg_read_pulse_out <= 1'b0;
         membuf_write_pulse_out     <= 1'b0;
         membuf_clear_out           <= 1'b0;
         mem_timing_off_out         <= 1'b0;
      end else if (clk_en_in) begin
         involuntary_fetch_xp_out   <= fetch_d && !skip_quiet;
         // An erasable address holds back the central read
         central_reg_read_pulse_out <= fetch_d &&
                                       !erasable_addr_in;
         membuf_write_pulse_out     <= fetch_d;
         membuf_clear_out           <= erasable_clear;
         mem_timing_off_out         <= central_copy;
      end
   end

   // Branch-qualified crosspoints; the branch encodings are local choices
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         skip_branch_xp_out <= 3'h0;
      end else if (clk_en_in) begin
         skip_branch_xp_out <= skip_branch_d;
      end
   end

   // Write bus: follows the transfer of the current pulse
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         write_bus_out <= '0;
      end else if (clk_en_in) begin
         write_bus_out <= bus_d;
      end
   end

   // Address register: loaded with the bus by the address write
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         addr_reg_out <= '0;
      end else if (clk_en_in) begin
         if (low_ten_d) begin
            addr_reg_out <= bus_d;
         end
      end
   end

   // Memory buffer: skip load, then central copy, then erasable clear
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         membuf_out <= '0;
      end else if (clk_en_in) begin
         if (skip_load) begin
            membuf_out <= erasable_word_in;
         end else if (central_copy) begin
            membuf_out <= central_reg_in;
         end else if (erasable_clear) begin
            membuf_out <= '0;
         end
      end
   end

endmodule : crosspoint_pulse_generator
`default_nettype wire

//--- verif/crosspoint_pulse_generator_asserts.sv
/* Port checker for the crosspoint pulse generator.
   Assumes a bind onto the top module; frozen cycles are not judged. */
`timescale 1ns/1ps
`default_nettype none
module xp_gen_checker #(
   parameter int BUS_W = 16,
   parameter int CELLS = 20
) (
   // Clock, counter control and branch
   input wire logic clk_in, rst_in, clk_en_in, branch_two_in,
   input wire logic next_seq_load_flop_in, peripheral_busy_in,
   input wire logic counter_instr_cmd_in, cond_skip_sub0_in,
   // Commands and data
   input wire logic skip_instr_cmd_in, double_add_sub0_in,
   input wire logic double_add_sub1_in, index_nine_cmd_in,
   input wire logic double_exchange_sub0_in, interrupt_count_cmd_in,
   input wire logic io_cmd_in, multiply_step_one_in, multiply_step_three_in,
   input wire logic divide_step_zero_in, index_fifteen_cmd_in,
   input wire logic divide_step_group_in,
   input wire logic [BUS_W-1:0] buffer_reg_in,
   // Watched outputs
   input wire logic [11:0] time_pulse_out,
   input wire logic [CELLS-1:0] counter_flops_out,
   input wire logic counter_t1_pulse_out, low_ten_bits_xp_out,
   input wire logic addr_reg_write_pulse_out, involuntary_fetch_xp_out,
   input wire logic [2:0] skip_branch_xp_out,
   input wire logic [BUS_W-1:0] write_bus_out, addr_reg_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in || !clk_en_in);
   // Command terms gathered once; outputs lag the sampling edge by one
   wire logic lt_cmd = skip_instr_cmd_in | double_add_sub0_in |
      double_add_sub1_in | index_nine_cmd_in | double_exchange_sub0_in |
      interrupt_count_cmd_in | io_cmd_in;
   wire logic fx_off = multiply_step_one_in | multiply_step_three_in |
      divide_step_zero_in | io_cmd_in | index_fifteen_cmd_in |
      divide_step_group_in;
   sequence s_set; $rose(|counter_flops_out); endsequence
   sequence s_clr; $fell(|counter_flops_out); endsequence
   property p_lt; low_ten_bits_xp_out == (time_pulse_out[0] && $past(lt_cmd));
   endproperty
   a_lt: assert property (p_lt) else $error("low ten xp wrong");
   property p_fx;
      involuntary_fetch_xp_out == (time_pulse_out[1] && !$past(fx_off));
   endproperty
   a_fx: assert property (p_fx) else $error("fetch xp wrong");
   property p_bus; low_ten_bits_xp_out |-> addr_reg_write_pulse_out &&
      write_bus_out == BUS_W'($past(buffer_reg_in[9:0]));
   endproperty
   a_bus: assert property (p_bus) else $error("bus wrong");
   property p_addr;
      addr_reg_write_pulse_out |=> addr_reg_out == $past(write_bus_out);
   endproperty
   a_addr: assert property (p_addr) else $error("addr reg wrong");
   property p_one; $onehot0(counter_flops_out); endproperty
   a_one: assert property (p_one) else $error("two cells");
   property p_set; s_set |-> time_pulse_out[1] &&
      $past(next_seq_load_flop_in && !peripheral_busy_in); endproperty
   a_set: assert property (p_set) else $error("bad set");
   property p_clr; s_clr |-> time_pulse_out[0]; endproperty
   a_clr: assert property (p_clr) else $error("early clear");
   property p_t1; counter_t1_pulse_out ==
      (time_pulse_out[0] && $past(counter_instr_cmd_in)); endproperty
   a_t1: assert property (p_t1) else $error("t1 pulse wrong");
   property p_br; skip_branch_xp_out[2] == (time_pulse_out[9] &&
      $past(cond_skip_sub0_in && !branch_two_in)); endproperty
   a_br: assert property (p_br) else $error("branch xp wrong");
endmodule : xp_gen_checker
bind crosspoint_pulse_generator xp_gen_checker #(.BUS_W(BUS_W),
   .CELLS(CELLS)) xp_gen_checker_inst (.*);
`default_nettype wire

//--- verif/xp_cmd_model.sv
/* Command generator stand-in: one command level chosen by the bench.
   Assumes sel_in changes by non-blocking assignment at a falling edge. */
`timescale 1ns/1ps
`default_nettype none
module xp_cmd_model (
   // Clock and choice
   input  wire logic        clk_in,
   input  wire logic [3:0]  sel_in,
   // Command levels
   output logic      [13:0] cmd_out
);
   // One command at a time, moved a cycle late so it never races the bench
   always_ff @(negedge clk_in) begin
      cmd_out <= 14'h0001 << sel_in;
   end
endmodule : xp_cmd_model
`default_nettype wire

//--- verif/crosspoint_pulse_generator_tb.sv
/* Self-checking bench for the crosspoint pulse generator.
   Assumes the command model and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module crosspoint_pulse_generator_tb;
   logic clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
   logic cycle_start_in = 1'b0, central_addr_in = 1'b0, erasable_addr_in = 1'b0;
   logic next_seq_load_flop_in = 1'b0, peripheral_busy_in = 1'b0;
   logic branch_one_in = 1'b0, branch_two_in = 1'b0;
   logic [19:0] cell_request_in = 20'h0;
   logic [15:0] buffer_reg_in = 16'h0, central_reg_in = 16'h0;
   logic [15:0] erasable_word_in = 16'h0;
   logic [3:0] sel = 4'hf;
   wire logic [13:0] cmd;
   wire logic counter_instr_cmd_in, cond_skip_sub0_in, skip_instr_cmd_in;
   wire logic double_add_sub0_in, double_add_sub1_in, index_nine_cmd_in;
   wire logic double_exchange_sub0_in, interrupt_count_cmd_in, io_cmd_in;
   wire logic multiply_step_one_in, multiply_step_three_in;
   wire logic divide_step_zero_in, index_fifteen_cmd_in, divide_step_group_in;
   wire logic [11:0] time_pulse_out;
   wire logic [19:0] counter_flops_out;
   wire logic counter_set_gate_out, counter_t1_pulse_out, low_ten_bits_xp_out;
   wire logic addr_reg_write_pulse_out, involuntary_fetch_xp_out;
   wire logic central_reg_read_pulse_out, membuf_write_pulse_out;
   wire logic membuf_clear_out, mem_timing_off_out;
   wire logic [2:0] skip_branch_xp_out;
   wire logic [15:0] write_bus_out, addr_reg_out, membuf_out;
   localparam logic [14:0] LT = 15'h007f;  // Commands giving low-ten xp
   localparam logic [14:0] FX = 15'h0fc0;  // Commands stopping the fetch
   int n_fail = 0;
   int checks_done = 0;
   assign {counter_instr_cmd_in, cond_skip_sub0_in, divide_step_group_in,
      index_fifteen_cmd_in, divide_step_zero_in, multiply_step_three_in,
      multiply_step_one_in, io_cmd_in, interrupt_count_cmd_in,
      double_exchange_sub0_in, index_nine_cmd_in, double_add_sub1_in,
      double_add_sub0_in, skip_instr_cmd_in} = cmd;
   crosspoint_pulse_generator crosspoint_pulse_generator_inst (.*);
   xp_cmd_model xp_cmd_model_inst (.clk_in(clk_in), .sel_in(sel), .cmd_out(cmd));
   // 40 MHz clock
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Bounded wait, at falling edges, for a given time pulse
   task automatic wait_tp(int k);
      int i;
      for (i = 0; i < 40 && time_pulse_out[k] !== 1'b1; i++)
         @(negedge clk_in);
      if (i == 40) begin
         n_fail++;
         results();
      end
   endtask : wait_tp
   task automatic t_cmds();
      for (int c = 0; c < 15; c++) begin
         wait_tp(9);
         sel <= 4'(c);
         buffer_reg_in <= 16'hf800 | 16'(c * 37);
         wait_tp(0);
         check("low ten", low_ten_bits_xp_out, LT[c]);
         check("addr write", addr_reg_write_pulse_out, LT[c]);
         check("bus", write_bus_out,
            LT[c] ? (buffer_reg_in & 16'h03ff) : 16'h0);
         check("t1 pulse", counter_t1_pulse_out, c == 13);
         wait_tp(1);
         check("fetch", involuntary_fetch_xp_out, !FX[c]);
         if (LT[c])
            check("addr reg", addr_reg_out, buffer_reg_in & 16'h03ff);
      end
      $display("command table done");
   endtask : t_cmds
   task automatic t_counter();
      wait_tp(9);
      cell_request_in <= 20'h00220;
      next_seq_load_flop_in <= 1'b1;
      wait_tp(1);
      check("cells", counter_flops_out, 20'h00020);
      check("gate", counter_set_gate_out, 1'b1);
      peripheral_busy_in <= 1'b1;
      wait_tp(10);
      check("held", counter_flops_out, 20'h00020);
      wait_tp(11);
      check("held t12", counter_flops_out, 20'h00020);
      wait_tp(0);
      check("cleared", counter_flops_out, 20'h0);
      wait_tp(1);
      check("busy set", counter_flops_out, 20'h0);
      $display("counter set done");
   endtask : t_counter
   task automatic t_skip(logic b1, logic b2);
      wait_tp(9);
      sel <= 4'd12;
      branch_one_in <= b1;
      branch_two_in <= b2;
      erasable_word_in <= {14'h0a5, b1, b2};
      wait_tp(2);
      check("quiet", {low_ten_bits_xp_out, involuntary_fetch_xp_out}, 2'b0);
      wait_tp(3);
      check("skip load", membuf_out, {14'h0a5, b1, b2});
      wait_tp(6);
      check("skip t7", skip_branch_xp_out, {1'b0, b1, b2});
      wait_tp(9);
      check("skip t10", skip_branch_xp_out, {!b2, 2'b0});
      $display("skip branch done");
   endtask : t_skip
   // Fetch paths for central and erasable addresses, then a freeze
   task automatic t_data();
      wait_tp(9);
      sel <= 4'd14;
      central_addr_in <= 1'b1;
      central_reg_in <= 16'h1234;
      wait_tp(1);
      check("central read", central_reg_read_pulse_out, 1'b1);
      check("buf write", membuf_write_pulse_out, 1'b1);
      check("timing off", mem_timing_off_out, 1'b1);
      check("copy", membuf_out, 16'h1234);
      central_addr_in <= 1'b0;
      erasable_addr_in <= 1'b1;
      wait_tp(9);
      wait_tp(1);
      check("read held", central_reg_read_pulse_out, 1'b0);
      check("clear", membuf_clear_out, 1'b1);
      check("cleared buf", membuf_out, 16'h0);
      clk_en_in <= 1'b0;
      repeat (3) @(negedge clk_in);
      check("freeze", time_pulse_out, 12'h002);
      clk_en_in <= 1'b1;
      $display("data path done");
   endtask : t_data
   // Reset, start the ring, then run the scenarios
   initial begin
      repeat (20) @(negedge clk_in);
      rst_in = 1'b0;
      cycle_start_in = 1'b1;
      @(negedge clk_in);
      cycle_start_in = 1'b0;
      t_cmds();
      t_counter();
      t_data();
      for (int b = 0; b < 4; b++)
         t_skip(b[1], b[0]);
      results();
   end
endmodule : crosspoint_pulse_generator_tb
`default_nettype wire
